// ### verilog/sirs_pkg.sv
// constants for the two-wire register slave
// assumes a 250 MHz core clock and a pulled-up bus
package sirs_pkg;
	// core clock period in ns
	localparam int CLK_PERIOD_NS = 4;
	// fastest bus clock served, in kHz
	localparam int SCL_MAX_KHZ = 400;
	// least high time of the bus clock, in ns
	localparam int SCL_HIGH_MIN_NS = 600;
	// same in core cycles, rounded up
	localparam int SCL_HIGH_MIN_CYC =
		(SCL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// fixed upper six bits of the target address
	localparam logic [5:0] ADDR_UPPER = 6'h34;
	// bits per byte on the wire
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// position of the auto-increment flag in the index byte
	localparam int INC_BIT = 7;
	// reset values
	localparam logic [6:0] REG_ADDR_RST = 7'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	// byte position within a transaction
	typedef enum logic [2:0] {
		PH_ADDR = 3'b001,
		PH_INDEX = 3'b010,
		PH_DATA = 3'b100
	} sirs_phase_e;
	// bit-level states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_RX = 7'b0000010,
		ST_ACK = 7'b0000100,
		ST_HOLD = 7'b0001000,
		ST_TX = 7'b0010000,
		ST_MACK = 7'b0100000,
		ST_IGNORE = 7'b1000000
	} sirs_state_e;
endpackage : sirs_pkg

// ### verilog/sirs_top.sv
// two-wire serial slave giving a bus master access to
// the sensor registers through a plain register port.
// assumes open-drain pads outside; register file answers
// read data combinationally from the address port.
// Behaviour
// - select pin high enables two-wire slave
// - data falls while clock high: start
// - data rises while clock high: stop
// - first byte address compared, answer on match
// - eighth address bit selects read or write
// - receiver pulls data low during acknowledge
// - acknowledge address, index and written data
// - index byte: seven address bits, increment flag
// - flag set advances address per data byte
// - write data follows index, stored per byte
// - next read byte only after master acknowledge
// - bytes of eight bits, first bit most significant
// - receiver may hold clock low to stall
// - refused address leaves data line high
// - works for standard and fast bus rates
// - lines only pulled low or released
`timescale 1ns/1ps
module sirs_top (
	// clock and reset
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	// pins
	input wire logic IF_SELECT_IN,
	input wire logic ADDRESS_LSB_STRAP_PIN_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SCL_OUT,
	output logic SCL_OE_OUT,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	// register port
	input wire logic STALL_IN,
	input wire logic [7:0] REG_RDATA_IN,
	output logic [6:0] REG_ADDR_OUT,
	output logic [7:0] REG_WDATA_OUT,
	output logic REG_WR_OUT,
	output logic REG_RD_OUT,
	// status
	output logic BUSY_OUT,
	output logic ADDRESSED_OUT
);
	import sirs_pkg::*;

	logic [1:0] scl_s_q;
	logic [1:0] sda_s_q;
	logic [1:0] sel_s_q;
	logic [1:0] strap_s_q;
	logic scl_d1_q;
	logic sda_d1_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic enabled;
	sirs_state_e state_q;
	sirs_phase_e phase_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic rw_q;
	logic inc_q;
	logic mack_q;
	logic [6:0] addr_q;
	logic sda_oe_q;
	logic scl_oe_q;
	logic wr_q;
	logic rd_q;
	logic [7:0] wdata_q;
	logic busy_q;
	logic hit_q;

	// next index, wraps in seven bits
	function automatic logic [6:0] next_addr(
		input logic [6:0] a, input logic inc);
		next_addr = inc ? 7'(a + 7'h01) : a;
	endfunction : next_addr

	// two-flop synchronisers for every pin
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			sel_s_q <= 2'h0;
			strap_s_q <= 2'h0;
		end else begin
			scl_s_q <= {scl_s_q[0], SCL_IN};
			sda_s_q <= {sda_s_q[0], SDA_IN};
			sel_s_q <= {sel_s_q[0], IF_SELECT_IN};
			strap_s_q <= {strap_s_q[0], ADDRESS_LSB_STRAP_PIN_IN};
		end
	end

	// delayed copies for edge finding, after the second flop
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= scl_s_q[1];
			sda_d1_q <= sda_s_q[1];
		end
	end

	// bus events; at 250 MHz even fast mode gives
	// well over a hundred samples per clock half
	assign enabled = sel_s_q[1];
	assign scl_rise = scl_s_q[1] & ~scl_d1_q;
	assign scl_fall = ~scl_s_q[1] & scl_d1_q;
	assign start_ev = scl_s_q[1] & scl_d1_q & ~sda_s_q[1] & sda_d1_q;
	assign stop_ev = scl_s_q[1] & scl_d1_q & sda_s_q[1] & ~sda_d1_q;

	// main sequencer
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_q <= ST_IDLE;
			phase_q <= PH_ADDR;
			cnt_q <= CNT_RST;
			sh_q <= BYTE_RST;
			rw_q <= 1'b0;
			inc_q <= 1'b0;
			mack_q <= 1'b0;
			addr_q <= REG_ADDR_RST;
			sda_oe_q <= 1'b0;
			scl_oe_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			wdata_q <= BYTE_RST;
			hit_q <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			if (!enabled) begin
				// four-wire mode owns the pins
				state_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				hit_q <= 1'b0;
			end else if (start_ev) begin
				// start or repeated start always restarts
				state_q <= ST_RX;
				phase_q <= PH_ADDR;
				cnt_q <= CNT_RST;
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				hit_q <= 1'b0;
			end else if (stop_ev) begin
				state_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				hit_q <= 1'b0;
			end else begin
				case (state_q)
					ST_RX: begin
						if (scl_rise) begin
							// most significant bit arrives first
							sh_q <= {sh_q[6:0], sda_s_q[1]};
							cnt_q <= 4'(cnt_q + 4'h1);
						end else if (scl_fall && cnt_q == BYTE_BITS) begin
							cnt_q <= CNT_RST;
							if (phase_q == PH_ADDR) begin
								if (sh_q[7:1] == {ADDR_UPPER, strap_s_q[1]}) begin
									rw_q <= sh_q[0];
									hit_q <= 1'b1;
									sda_oe_q <= 1'b1;
									state_q <= ST_ACK;
								end else begin
									// released line reads as refusal
									state_q <= ST_IGNORE;
								end
							end else if (phase_q == PH_INDEX) begin
								addr_q <= sh_q[6:0];
								inc_q <= sh_q[INC_BIT];
								sda_oe_q <= 1'b1;
								state_q <= ST_ACK;
							end else begin
								wdata_q <= sh_q;
								wr_q <= 1'b1;
								sda_oe_q <= 1'b1;
								state_q <= ST_ACK;
							end
						end
					end
					ST_ACK: begin
						// low held across the whole high phase
						if (scl_fall) begin
							sda_oe_q <= 1'b0;
							scl_oe_q <= 1'b1;
							state_q <= ST_HOLD;
							if (phase_q == PH_DATA) begin
								addr_q <= next_addr(addr_q, inc_q);
							end
						end
					end
					ST_HOLD: begin
						// clock kept low while the user stalls
						if (!STALL_IN) begin
							scl_oe_q <= 1'b0;
							cnt_q <= CNT_RST;
							if (rw_q && phase_q != PH_INDEX) begin
								// read: load and drive first bit
								sh_q <= REG_RDATA_IN;
								rd_q <= 1'b1;
								sda_oe_q <= ~REG_RDATA_IN[7];
								phase_q <= PH_DATA;
								state_q <= ST_TX;
							end else begin
								phase_q <= (phase_q == PH_ADDR) ? PH_INDEX : PH_DATA;
								state_q <= ST_RX;
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (cnt_q == 4'(BYTE_BITS - 4'h1)) begin
								// release for the master's answer
								sda_oe_q <= 1'b0;
								cnt_q <= CNT_RST;
								addr_q <= next_addr(addr_q, inc_q);
								state_q <= ST_MACK;
							end else begin
								sh_q <= {sh_q[6:0], 1'b0};
								sda_oe_q <= ~sh_q[6];
								cnt_q <= 4'(cnt_q + 4'h1);
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							mack_q <= ~sda_s_q[1];
						end else if (scl_fall) begin
							if (mack_q) begin
								scl_oe_q <= 1'b1;
								state_q <= ST_HOLD;
							end else begin
								state_q <= ST_IGNORE;
							end
						end
					end
					ST_IGNORE: begin
						sda_oe_q <= 1'b0;
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// bus busy between start and stop
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			busy_q <= 1'b0;
		end else if (!enabled || stop_ev) begin
			busy_q <= 1'b0;
		end else if (start_ev) begin
			busy_q <= 1'b1;
		end
	end

	// pads only ever pull low; enable carries the level
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE_OUT = scl_oe_q;
	assign SDA_OE_OUT = sda_oe_q;
	assign REG_ADDR_OUT = addr_q;
	assign REG_WDATA_OUT = wdata_q;
	assign REG_WR_OUT = wr_q;
	assign REG_RD_OUT = rd_q;
	assign BUSY_OUT = busy_q;
	assign ADDRESSED_OUT = hit_q;

	// pulses per transaction for the burst covers; a small
	// saturating count keeps the covers free of long ranges
	logic [1:0] wr_n_q;
	logic [1:0] rd_n_q;
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			wr_n_q <= 2'h0;
			rd_n_q <= 2'h0;
		end else if (start_ev) begin
			wr_n_q <= 2'h0;
			rd_n_q <= 2'h0;
		end else begin
			if (wr_q && wr_n_q != 2'h3) begin
				wr_n_q <= 2'(wr_n_q + 2'h1);
			end
			if (rd_q && rd_n_q != 2'h3) begin
				rd_n_q <= 2'(rd_n_q + 2'h1);
			end
		end
	end

	// checks
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);

	sel_low_a: assert property (!enabled |=> !sda_oe_q && !scl_oe_q)
		else $error("pins driven while two-wire mode off");
	start_busy_a: assert property (enabled && start_ev |=> busy_q)
		else $error("start not marked busy");
	stop_idle_a: assert property (enabled && stop_ev |=> state_q == ST_IDLE && !busy_q)
		else $error("stop did not return to idle");
	miss_a: assert property (state_q == ST_RX && phase_q == PH_ADDR && scl_fall
		&& cnt_q == BYTE_BITS && !start_ev && !stop_ev && enabled
		&& sh_q[7:1] != {ADDR_UPPER, strap_s_q[1]} |=> state_q == ST_IGNORE && !sda_oe_q)
		else $error("foreign address answered");
	hit_ack_a: assert property (state_q == ST_RX && phase_q == PH_ADDR && scl_fall
		&& cnt_q == BYTE_BITS && !start_ev && !stop_ev && enabled
		&& sh_q[7:1] == {ADDR_UPPER, strap_s_q[1]} |=> sda_oe_q && hit_q && rw_q == $past(sh_q[0]))
		else $error("own address not acknowledged");
	ack_hold_a: assert property (state_q == ST_ACK && scl_s_q[1] |-> sda_oe_q)
		else $error("acknowledge released in clock high");
	wr_ack_a: assert property (wr_q |-> sda_oe_q && state_q == ST_ACK)
		else $error("written byte without acknowledge");
	ignore_a: assert property (state_q == ST_IGNORE && !start_ev |=> !sda_oe_q)
		else $error("data line driven while ignoring");
	nak_a: assert property (state_q == ST_MACK && scl_fall && !mack_q && !start_ev
		&& !stop_ev && enabled |=> state_q == ST_IGNORE ##1 !sda_oe_q)
		else $error("transmit continued after no acknowledge");
	tx_stable_a: assert property (state_q == ST_TX && scl_s_q[1] && scl_d1_q
		&& !start_ev && enabled |=> $stable(sda_oe_q) || state_q != ST_TX)
		else $error("data changed while clock high");
	stall_a: assert property (state_q == ST_HOLD && STALL_IN && enabled |=> scl_oe_q)
		else $error("stall did not hold the clock");
	inc_a: assert property (state_q == ST_ACK && phase_q == PH_DATA && scl_fall && inc_q && enabled
		|=> addr_q == 7'($past(addr_q) + 7'h01))
		else $error("index not advanced");
	rd_inc_a: assert property (state_q == ST_TX && scl_fall && cnt_q == 4'(BYTE_BITS - 4'h1) && inc_q
		&& enabled |=> addr_q == 7'($past(addr_q) + 7'h01))
		else $error("read index not advanced");

	write_c: cover property (wr_q && wr_n_q != 2'h0);
	read_c: cover property (rd_q && rd_n_q != 2'h0);
	nak_c: cover property (state_q == ST_MACK ##1 state_q == ST_IGNORE);
	stall_c: cover property (scl_oe_q [*8]);

endmodule : sirs_top

// ### testbench/sirs_master.sv
// two-wire bus master model for the register slave
// assumes the bench resolves both open-drain lines
`timescale 1ns/1ps
module sirs_master (
	// clock
	input wire logic clk_in,
	// wire levels
	input wire logic scl_in,
	input wire logic sda_in,
	// pull-down enables
	output logic scl_oe_out,
	output logic sda_oe_out
);
	// bus clock at about 388 kHz: 1.48 us low, 1.1 us high
	localparam int LO_CYC = 350;
	localparam int HI_CYC = 275;
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end
	// all pin changes land just after a core edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : step
	// bounded wait while the slave stretches the clock
	task automatic rise();
		scl_oe_out = 1'b0;
		for (int k = 0; k < 40000 && scl_in !== 1'b1; k++) step(1);
	endtask : rise
	// start and repeated start alike
	task automatic start();
		sda_oe_out = 1'b0;
		step(LO_CYC);
		rise();
		step(HI_CYC);
		sda_oe_out = 1'b1;
		step(HI_CYC);
		scl_oe_out = 1'b1;
	endtask : start
	task automatic stop();
		step(20);
		sda_oe_out = 1'b1;
		step(LO_CYC);
		rise();
		step(HI_CYC);
		sda_oe_out = 1'b0;
		step(HI_CYC);
	endtask : stop
	// data moves well after the fall, never beside it
	task automatic bit_io(input logic b, output logic r);
		step(20);
		sda_oe_out = !b;
		step(LO_CYC);
		rise();
		step(HI_CYC / 2);
		r = sda_in;
		step(HI_CYC / 2);
		scl_oe_out = 1'b1;
	endtask : bit_io
	task automatic send(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
		bit_io(1'b1, ack);
	endtask : send
	task automatic recv(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!mack, r);
	endtask : recv
endmodule : sirs_master

// ### testbench/sirs_top_test.sv
// self-checking bench for the two-wire register slave
// assumes the master model of sirs_master.sv
`timescale 1ns/1ps
module sirs_top_test;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic if_select = 1'b1;
	logic strap = 1'b1;
	logic stall = 1'b0;
	logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_w, sda_w, rd_pulse, wr_pulse, busy, addressed;
	logic [6:0] reg_addr;
	logic [7:0] wdata;
	logic [15:0] wr_q[$];
	int n_rd = 0;
	int n_fail = 0;
	int cmp_count = 0;
	always #2 mclk = !mclk;
	// pulled-up wired lines
	assign scl_w = !(scl_oe | m_scl_oe);
	assign sda_w = !(sda_oe | m_sda_oe);
	// register file contents seen by the slave
	function automatic logic [7:0] rd_val(input logic [6:0] a);
		return {1'b0, a} ^ 8'hC3;
	endfunction : rd_val
	sirs_top i_sirs_top (.MCLK_IN(mclk), .RSTN_IN(rstn), .IF_SELECT_IN(if_select),
		.ADDRESS_LSB_STRAP_PIN_IN(strap), .SCL_IN(scl_w), .SDA_IN(sda_w), .SCL_OUT(),
		.SCL_OE_OUT(scl_oe), .SDA_OUT(), .SDA_OE_OUT(sda_oe), .STALL_IN(stall),
		.REG_RDATA_IN(rd_val(reg_addr)), .REG_ADDR_OUT(reg_addr), .REG_WDATA_OUT(wdata),
		.REG_WR_OUT(wr_pulse), .REG_RD_OUT(rd_pulse), .BUSY_OUT(busy), .ADDRESSED_OUT(addressed));
	sirs_master i_sirs_master (.clk_in(mclk), .scl_in(scl_w), .sda_in(sda_w),
		.scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe));
	// log register port strobes
	always @(posedge mclk) begin
		if (wr_pulse === 1'b1) wr_q.push_back({1'b0, reg_addr, wdata});
		if (rd_pulse === 1'b1) n_rd++;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	// one address byte, then one more byte that only an addressed slave takes or, on a read, sends
	task automatic probe(input logic sel, input logic st, input logic [7:0] a, input logic exp);
		logic ack;
		logic [7:0] d;
		if_select = sel;
		strap = st;
		i_sirs_master.step(10);
		i_sirs_master.start();
		i_sirs_master.send(a, ack);
		check("probe ack", 8'(ack), 8'(exp));
		check("probe hit", 8'(addressed), 8'(!exp));
		if (a[0] && !exp) begin
			// index left behind by the read test
			i_sirs_master.recv(1'b0, d);
			check("probe read", d, rd_val(7'h12));
		end else begin
			i_sirs_master.send(8'h00, ack);
			check("probe next", 8'(ack), 8'(exp));
		end
		i_sirs_master.stop();
	endtask : probe
	// hang guard, a run takes about 98000 cycles
	initial begin
		repeat (120000) @(posedge mclk);
		n_fail++;
		$display("BAD watchdog expected end seen hang");
		print_verdict();
	end
	initial begin
		logic ack;
		logic [7:0] d;
		repeat (3) @(posedge mclk);
		#1;
		rstn = 1'b1;
		i_sirs_master.step(4);
		check("idle", {4'h0, sda_oe, scl_oe, busy, addressed}, 8'h00);
		check("reset index", 8'(reg_addr), 8'h00);
		$display("test reset done");
		i_sirs_master.start();
		check("busy", 8'(busy), 8'h01);
		i_sirs_master.send(8'hD2, ack);
		check("ack address", 8'(ack), 8'h00);
		check("addressed", 8'(addressed), 8'h01);
		i_sirs_master.send(8'h85, ack);
		check("index", {ack, reg_addr}, 8'h05);
		i_sirs_master.send(8'hA5, ack);
		i_sirs_master.send(8'h5A, ack);
		check("ack data", 8'(ack), 8'h00);
		i_sirs_master.stop();
		check("free", 8'(busy), 8'h00);
		check("writes", 8'(wr_q.size()), 8'h02);
		check("wr0 at", wr_q[0][15:8], 8'h05);
		check("wr0 data", wr_q[0][7:0], 8'hA5);
		check("wr1 at", wr_q[1][15:8], 8'h06);
		check("wr1 data", wr_q[1][7:0], 8'h5A);
		$display("test write done");
		i_sirs_master.start();
		i_sirs_master.send(8'hD2, ack);
		i_sirs_master.send(8'h90, ack);
		i_sirs_master.start();
		stall = 1'b1;
		i_sirs_master.send(8'hD3, ack);
		check("ack read", 8'(ack), 8'h00);
		i_sirs_master.step(1000);
		check("stretch", 8'(scl_oe), 8'h01);
		stall = 1'b0;
		i_sirs_master.recv(1'b1, d);
		check("rd0", d, rd_val(7'h10));
		i_sirs_master.recv(1'b0, d);
		check("rd1", d, rd_val(7'h11));
		i_sirs_master.step(200);
		check("nack release", {6'h00, sda_oe, scl_oe}, 8'h00);
		check("loads", 8'(n_rd), 8'h02);
		check("next index", 8'(reg_addr), 8'h12);
		i_sirs_master.stop();
		$display("test read done");
		probe(1'b0, 1'b1, 8'hD2, 1'b1);
		probe(1'b1, 1'b1, 8'hD0, 1'b1);
		probe(1'b1, 1'b0, 8'hD1, 1'b0);
		$display("test address done");
		print_verdict();
	end
endmodule : sirs_top_test
